// >>> verilog/tpw_top.sv
/*
 * three-phase complementary pwm generator with dead time, trough duty
 * reload, trough conversion sequencing and an overcurrent stop latch.
 * assumes: one 40 MHz clock; the stop pin is asynchronous; the converter
 * runs on mclk, takes one start pulse and answers with one valid pulse.
 */
`default_nettype none
module tpw_top
	import tpw_pkg::*;
#(
	parameter int CNT_W = TPW_CNT_W,
	parameter logic [TPW_CNT_W-1:0] PERIOD = TPW_PERIOD_CMP,
	parameter int DEAD_CYC = TPW_DEAD_CYC,
	parameter int OC_SAMPLES = TPW_OC_SAMPLES
)
(
	input wire logic mclk, // 40 MHz clock
	input wire logic rst_n, // synchronous reset, low active
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic overcurrent_stop_input_n, // async stop pin, low requests stop
	output logic gate_up, // U upper, second channel D pin
	output logic gate_un, // U lower, second channel B pin
	output logic gate_vp, // V upper, second channel C pin
	output logic gate_vn, // V lower, second channel A pin
	output logic gate_wp, // W upper, first channel D pin
	output logic gate_wn, // W lower, first channel B pin
	output logic trough_conversion_trigger, // one-cycle pulse at trough, only while conversions are enabled
	output logic adc_start, // one-cycle conversion start
	output logic [1:0] adc_channel, // channel for current conversion
	input wire logic [TPW_RES_W-1:0] adc_data, // conversion result
	input wire logic adc_valid, // one-cycle result strobe
	output logic irq, // level interrupt
	output logic [3:0] irq_level // priority of highest pending source
);
	// carrier and control state
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic up_q, up_d;
	logic run_q, out_en_q, adc_en_q, stop_q, short_q;
	logic [CNT_W-1:0] buf_q [3];
	logic [CNT_W-1:0] act_q [3];
	logic [TPW_RES_W-1:0] res_vdc_q, res_iu_q, res_iw_q;
	logic [1:0] istat_q, istat_d, imask_q;
	logic [31:0] rdata_q, rdata_d;
	logic [5:0] gate_q, gate_d;
	logic trig_q, start_q;
	logic [1:0] chan_q;
	logic irq_q;
	logic [3:0] lvl_q;
	tpw_adc_type adc_st_q, adc_st_d;
	// stop pin synchroniser and filter
	logic oc_meta_q, oc_sync_q, oc_armed_q;
	logic [4:0] oc_cnt_q;

	// register decode
	wire wr_cmd = reg_wr && (reg_addr == TPW_ADDR_CMD);
	wire wr_du = reg_wr && (reg_addr == TPW_ADDR_DUTY_U);
	wire wr_dv = reg_wr && (reg_addr == TPW_ADDR_DUTY_V);
	wire wr_dw = reg_wr && (reg_addr == TPW_ADDR_DUTY_W);
	wire wr_istat = reg_wr && (reg_addr == TPW_ADDR_IRQ_STAT);
	wire wr_imask = reg_wr && (reg_addr == TPW_ADDR_IRQ_MASK);
	wire cmd_start = wr_cmd && reg_wdata[TPW_CMD_START];
	wire cmd_stop = wr_cmd && reg_wdata[TPW_CMD_STOP];
	wire cmd_out_on = wr_cmd && reg_wdata[TPW_CMD_OUT_ON];
	wire cmd_out_off = wr_cmd && reg_wdata[TPW_CMD_OUT_OFF];
	wire cmd_adc_on = wr_cmd && reg_wdata[TPW_CMD_ADC_ON];
	wire cmd_adc_off = wr_cmd && reg_wdata[TPW_CMD_ADC_OFF];
	wire cmd_clr_stop = wr_cmd && reg_wdata[TPW_CMD_CLR_STOP];
	wire [CNT_W-1:0] wr_duty = reg_wdata[CNT_W-1:0];

	// trough is the compare match of the falling count with the bottom value
	wire trough = run_q && !up_q && (cnt_q == TPW_TROUGH_CMP);

	// up-down carrier; holds its value while halted
	always_comb
	begin
		cnt_d = cnt_q;
		up_d = up_q;
		if (run_q)
		begin
			if (up_q)
			begin
				if (cnt_q >= PERIOD)
				begin
					up_d = 1'b0;
					cnt_d = cnt_q - 1'b1;
				end
				else
					cnt_d = cnt_q + 1'b1;
			end
			else if (cnt_q == TPW_TROUGH_CMP)
			begin
				up_d = 1'b1;
				cnt_d = cnt_q + 1'b1;
			end
			else
				cnt_d = cnt_q - 1'b1;
		end
	end

	// overcurrent: falling edge arms a run of low samples; the sixteenth acts
	wire oc_fire = oc_armed_q && !oc_sync_q && (oc_cnt_q == 5'(OC_SAMPLES - 1));

	// shoot-through: both switches of any pair high on the pins
	wire shoot = (gate_q[0] && gate_q[1]) || (gate_q[2] && gate_q[3]) || (gate_q[4] && gate_q[5]);

	// stop latch: a new trip wins over a clear in the same cycle
	wire stop_set = oc_fire || shoot;
	wire gates_allowed = run_q && out_en_q && !stop_q && !stop_set;

	// dead-time generation, one instance per phase
	wire [CNT_W-1:0] duty_now [3];
	wire [2:0] hi_w, lo_w;
	assign duty_now[0] = act_q[0];
	assign duty_now[1] = act_q[1];
	assign duty_now[2] = act_q[2];
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_phase
			logic raw_q;
			logic [TPW_DT_W-1:0] dt_q;
			// upper leg wanted while duty exceeds the carrier
			wire raw_w = duty_now[gi] > cnt_q;
			// on each change both legs rest off for the dead time
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
				begin
					raw_q <= 1'b0;
					dt_q <= TPW_DT_W'(DEAD_CYC);
				end
				else if (raw_w != raw_q)
				begin
					raw_q <= raw_w;
					dt_q <= TPW_DT_W'(DEAD_CYC);
				end
				else if (dt_q != '0)
					dt_q <= dt_q - 1'b1;
			end
			assign hi_w[gi] = raw_q && (dt_q == '0);
			assign lo_w[gi] = !raw_q && (dt_q == '0);
		end
	endgenerate

	// pin order {wn, wp, vn, vp, un, up}; high means switch on
	assign gate_d = gates_allowed ? {lo_w[2], hi_w[2], lo_w[1], hi_w[1], lo_w[0], hi_w[0]} : 6'h00;

	// conversion sequencer: bus voltage, then U current, then W current
	wire seq_go = trough && adc_en_q && (adc_st_q == TPW_ADC_IDLE);
	wire seq_done = adc_valid && (adc_st_q == TPW_ADC_IW);
	always_comb
	begin
		adc_st_d = adc_st_q;
		case (adc_st_q)
			TPW_ADC_IDLE:
				if (seq_go)
					adc_st_d = TPW_ADC_VDC;
			TPW_ADC_VDC:
				if (adc_valid)
					adc_st_d = TPW_ADC_IU;
			TPW_ADC_IU:
				if (adc_valid)
					adc_st_d = TPW_ADC_IW;
			TPW_ADC_IW:
				if (adc_valid)
					adc_st_d = TPW_ADC_IDLE;
			default:
				adc_st_d = TPW_ADC_IDLE;
		endcase
	end
	wire seq_next = adc_valid && (adc_st_q == TPW_ADC_VDC || adc_st_q == TPW_ADC_IU);
	wire [1:0] chan_d = seq_go ? TPW_CH_VDC : ((adc_st_q == TPW_ADC_VDC) ? TPW_CH_U : TPW_CH_W);

	// sticky interrupt status, write one to clear; a fresh event wins
	wire conv_evt = seq_done && adc_en_q;
	wire [1:0] evt = {oc_fire || shoot, conv_evt};
	assign istat_d = (istat_q & ~(wr_istat ? reg_wdata[1:0] : 2'h0)) | evt;
	wire [1:0] pend = istat_d & imask_q;
	// overcurrent source outranks conversion done
	wire [3:0] lvl_d = pend[TPW_IRQ_OFF] ? TPW_LVL_OFF : (pend[TPW_IRQ_CONV] ? TPW_LVL_CONV : 4'h0);

	// read mux; unmapped addresses read zero
	wire [31:0] status_w = {26'h000_0000, adc_st_q != TPW_ADC_IDLE, short_q, stop_q, adc_en_q, out_en_q, run_q};
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				TPW_ADDR_STATUS: rdata_d = status_w;
				TPW_ADDR_DUTY_U: rdata_d = 32'(buf_q[0]);
				TPW_ADDR_DUTY_V: rdata_d = 32'(buf_q[1]);
				TPW_ADDR_DUTY_W: rdata_d = 32'(buf_q[2]);
				TPW_ADDR_RES_VDC: rdata_d = 32'(res_vdc_q);
				TPW_ADDR_RES_IU: rdata_d = 32'(res_iu_q);
				TPW_ADDR_RES_IW: rdata_d = 32'(res_iw_q);
				TPW_ADDR_IRQ_STAT: rdata_d = 32'(istat_q);
				TPW_ADDR_IRQ_MASK: rdata_d = 32'(imask_q);
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// carrier counter
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_q <= TPW_TROUGH_CMP;
			up_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			up_q <= up_d;
		end
	end

	// software control bits; stop wins over start if both are written
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			run_q <= 1'b0;
			out_en_q <= 1'b0;
			adc_en_q <= 1'b0;
		end
		else
		begin
			if (cmd_stop)
				run_q <= 1'b0;
			else if (cmd_start)
				run_q <= 1'b1;
			// a trip drops the enable so re-enabling is a deliberate act
			if (stop_set || cmd_out_off)
				out_en_q <= 1'b0;
			else if (cmd_out_on)
				out_en_q <= 1'b1;
			if (cmd_adc_off)
				adc_en_q <= 1'b0;
			else if (cmd_adc_on)
				adc_en_q <= 1'b1;
		end
	end

	// stop latch and shoot-through flag
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stop_q <= 1'b0;
			short_q <= 1'b0;
		end
		else
		begin
			if (stop_set)
				stop_q <= 1'b1;
			else if (cmd_clr_stop)
				stop_q <= 1'b0;
			if (shoot)
				short_q <= 1'b1;
			else if (cmd_clr_stop)
				short_q <= 1'b0;
		end
	end

	// duty buffers and trough reload
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 3; i++)
			begin
				buf_q[i] <= TPW_DUTY_RST;
				act_q[i] <= TPW_DUTY_RST;
			end
		end
		else
		begin
			if (wr_du)
				buf_q[0] <= wr_duty;
			if (wr_dv)
				buf_q[1] <= wr_duty;
			if (wr_dw)
				buf_q[2] <= wr_duty;
			if (trough)
			begin
				for (int i = 0; i < 3; i++)
					act_q[i] <= buf_q[i];
			end
		end
	end

	// stop pin: two flops, then edge arm and sample count
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			oc_meta_q <= 1'b1;
			oc_sync_q <= 1'b1;
			oc_armed_q <= 1'b0;
			oc_cnt_q <= 5'h00;
		end
		else
		begin
			oc_meta_q <= overcurrent_stop_input_n;
			oc_sync_q <= oc_meta_q;
			// a level held low is ignored until the pin has been high again
			if (oc_sync_q)
			begin
				oc_armed_q <= 1'b1;
				oc_cnt_q <= 5'h00;
			end
			else if (oc_fire)
				oc_armed_q <= 1'b0;
			else if (oc_armed_q)
				oc_cnt_q <= oc_cnt_q + 1'b1;
		end
	end

	// conversion sequencer and result holding
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			adc_st_q <= TPW_ADC_IDLE;
			start_q <= 1'b0;
			chan_q <= TPW_CH_VDC;
			trig_q <= 1'b0;
			res_vdc_q <= '0;
			res_iu_q <= '0;
			res_iw_q <= '0;
		end
		else
		begin
			adc_st_q <= adc_st_d;
			trig_q <= trough && adc_en_q;
			start_q <= seq_go || seq_next;
			if (seq_go || seq_next)
				chan_q <= chan_d;
			if (adc_valid && adc_st_q == TPW_ADC_VDC)
				res_vdc_q <= adc_data;
			if (adc_valid && adc_st_q == TPW_ADC_IU)
				res_iu_q <= adc_data;
			if (seq_done)
				res_iw_q <= adc_data;
		end
	end

	// interrupt registers and outputs
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			istat_q <= 2'h0;
			imask_q <= TPW_MASK_RST;
			irq_q <= 1'b0;
			lvl_q <= 4'h0;
			rdata_q <= 32'h0000_0000;
			gate_q <= 6'h00;
		end
		else
		begin
			istat_q <= istat_d;
			if (wr_imask)
				imask_q <= reg_wdata[1:0];
			irq_q <= |pend;
			lvl_q <= lvl_d;
			rdata_q <= rdata_d;
			gate_q <= gate_d;
		end
	end

	// pin mapping: U on second channel B/D, V on its A/C, W on first B/D
	assign gate_up = gate_q[0];
	assign gate_un = gate_q[1];
	assign gate_vp = gate_q[2];
	assign gate_vn = gate_q[3];
	assign gate_wp = gate_q[4];
	assign gate_wn = gate_q[5];
	assign reg_rdata = rdata_q;
	assign trough_conversion_trigger = trig_q;
	assign adc_start = start_q;
	assign adc_channel = chan_q;
	assign irq = irq_q;
	assign irq_level = lvl_q;
endmodule
`default_nettype wire

// >>> pkg/tpw_pkg.sv
/*
 * constants shared by the three-phase pwm block: register map, command bits,
 * field positions, reset values and timing counts.
 * assumes a 40 MHz peripheral clock and a 12-bit result converter.
 */
`default_nettype none
package tpw_pkg;
	// timing, in nanoseconds as specified; only the dead time is converted to clock cycles
	localparam int TPW_CLK_NS = 25;
	localparam int TPW_CARRIER_NS = 50000;
	localparam int TPW_DEAD_NS = 2000;
	// least time rounds up
	localparam int TPW_DEAD_CYC = (TPW_DEAD_NS + TPW_CLK_NS - 1) / TPW_CLK_NS;
	localparam int TPW_CNT_W = 12;
	localparam int TPW_DT_W = 8;
	localparam logic [TPW_CNT_W-1:0] TPW_PERIOD_CMP = 12'hca8;
	// carrier count value that is the trough compare match
	localparam logic [TPW_CNT_W-1:0] TPW_TROUGH_CMP = 12'h000;
	localparam int TPW_OC_SAMPLES = 16;
	localparam int TPW_RES_W = 12;
	// register offsets (byte addresses)
	localparam logic [7:0] TPW_ADDR_CMD = 8'h00;
	localparam logic [7:0] TPW_ADDR_STATUS = 8'h04;
	localparam logic [7:0] TPW_ADDR_DUTY_U = 8'h08;
	localparam logic [7:0] TPW_ADDR_DUTY_V = 8'h0c;
	localparam logic [7:0] TPW_ADDR_DUTY_W = 8'h10;
	localparam logic [7:0] TPW_ADDR_RES_VDC = 8'h14;
	localparam logic [7:0] TPW_ADDR_RES_IU = 8'h18;
	localparam logic [7:0] TPW_ADDR_RES_IW = 8'h1c;
	localparam logic [7:0] TPW_ADDR_IRQ_STAT = 8'h20;
	localparam logic [7:0] TPW_ADDR_IRQ_MASK = 8'h24;
	// command register bit positions (write one to act)
	localparam int TPW_CMD_START = 0;
	localparam int TPW_CMD_STOP = 1;
	localparam int TPW_CMD_OUT_ON = 2;
	localparam int TPW_CMD_OUT_OFF = 3;
	localparam int TPW_CMD_ADC_ON = 4;
	localparam int TPW_CMD_ADC_OFF = 5;
	localparam int TPW_CMD_CLR_STOP = 6;
	// interrupt status bit positions
	localparam int TPW_IRQ_CONV = 0;
	localparam int TPW_IRQ_OFF = 1;
	localparam logic [3:0] TPW_LVL_CONV = 4'ha;
	localparam logic [3:0] TPW_LVL_OFF = 4'hf;
	// converter channel numbers
	localparam logic [1:0] TPW_CH_U = 2'h0;
	localparam logic [1:0] TPW_CH_W = 2'h2;
	localparam logic [1:0] TPW_CH_VDC = 2'h3;
	// reset values
	localparam logic [TPW_CNT_W-1:0] TPW_DUTY_RST = 12'h000;
	localparam logic [1:0] TPW_MASK_RST = 2'h0;
	typedef enum logic [1:0] {TPW_ADC_IDLE, TPW_ADC_VDC, TPW_ADC_IU, TPW_ADC_IW} tpw_adc_type;
endpackage
`default_nettype wire

// >>> verification/tpw_assertions.sv
/* port checker for tpw_top.
   assumes one clock and the bind at the foot of this file. */
`default_nettype none
module tpw_assertions
	import tpw_pkg::*;
#(
	parameter int DEAD_CYC = TPW_DEAD_CYC,
	parameter int OC_SAMPLES = TPW_OC_SAMPLES
)
(
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic overcurrent_stop_input_n, // stop pin
	input wire logic gate_up, // gate
	input wire logic gate_un, // gate
	input wire logic gate_vp, // gate
	input wire logic gate_vn, // gate
	input wire logic gate_wp, // gate
	input wire logic gate_wn, // gate
	input wire logic trough_conversion_trigger, // trigger
	input wire logic adc_start, // start
	input wire logic [1:0] adc_channel, // channel
	input wire logic adc_valid, // result strobe
	input wire logic irq, // interrupt
	input wire logic [3:0] irq_level // level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed_q;
	logic [5:0] low_q;
	wire logic any_gate = gate_up | gate_un | gate_vp | gate_vn | gate_wp | gate_wn;
	// consecutive low samples once armed; saturates so a long stop stays visible
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			armed_q <= 1'b0;
			low_q <= 6'h00;
		end
		else if (overcurrent_stop_input_n)
		begin
			armed_q <= 1'b1;
			low_q <= 6'h00;
		end
		else if (armed_q && low_q != 6'h3f)
			low_q <= low_q + 6'h01;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside slot");
	chk_trig_conv: assert property (trough_conversion_trigger |-> adc_start && adc_channel == TPW_CH_VDC)
		else $error("trigger without voltage start");
	chk_seq_u: assert property (adc_valid && adc_channel == TPW_CH_VDC |=> adc_start && adc_channel == TPW_CH_U)
		else $error("u current not next");
	chk_seq_w: assert property (adc_valid && adc_channel == TPW_CH_U |=> adc_start && adc_channel == TPW_CH_W)
		else $error("w current not next");
	chk_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("start too long");
	chk_trig_gap: assert property (trough_conversion_trigger |=> !trough_conversion_trigger [*8])
		else $error("triggers too close");
	chk_no_shoot: assert property (!(gate_up && gate_un) && !(gate_vp && gate_vn) && !(gate_wp && gate_wn))
		else $error("pair both on");
	chk_dead_u: assert property ($rose(gate_up) |-> !$past(gate_un, DEAD_CYC))
		else $error("u dead time short");
	chk_oc_off: assert property (low_q >= OC_SAMPLES + 4 |-> !any_gate)
		else $error("gates on under stop");
	chk_lvl_irq: assert property (irq_level != 4'h0 |-> irq)
		else $error("level without irq");
	cover property (trough_conversion_trigger);
	cover property (irq_level == TPW_LVL_OFF);
	cover property (adc_valid && adc_channel == TPW_CH_W);
endmodule
bind tpw_top tpw_assertions #(.DEAD_CYC(DEAD_CYC), .OC_SAMPLES(OC_SAMPLES)) u_chk (.mclk, .rst_n,
	.reg_rd, .reg_rdata, .overcurrent_stop_input_n, .gate_up, .gate_un, .gate_vp, .gate_vn, .gate_wp,
	.gate_wn, .trough_conversion_trigger, .adc_start, .adc_channel, .adc_valid, .irq, .irq_level);
`default_nettype wire

// >>> verification/tpw_adc_model.sv
/* converter model: one result per start, after a short or long wait.
   assumes the block's clock. */
`default_nettype none
module tpw_adc_model
	import tpw_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst_n, // reset, low active
	input wire logic slow, // long conversion when high
	input wire logic adc_start, // start pulse
	input wire logic [1:0] adc_channel, // channel
	output logic [TPW_RES_W-1:0] adc_data, // result
	output logic adc_valid // result strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q;
	logic [2:0] wait_q;
	logic [1:0] ch_q;
	// fixed code per channel; the bus toggles between strobes so a stale read shows
	always_ff @(posedge mclk)
	begin
		adc_valid <= 1'b0;
		adc_data <= ~adc_data;
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			adc_data <= 12'h000;
		end
		else if (adc_start)
		begin
			busy_q <= 1'b1;
			ch_q <= adc_channel;
			wait_q <= slow ? 3'h5 : 3'h0;
		end
		else if (busy_q && wait_q != 3'h0)
			wait_q <= wait_q - 3'h1;
		else if (busy_q)
		begin
			busy_q <= 1'b0;
			adc_valid <= 1'b1;
			adc_data <= {10'h168, ch_q};
		end
	end
endmodule
`default_nettype wire

// >>> verification/tpw_top_tb.sv
/* bench for tpw_top with the converter model.
   assumes PERIOD 20 and DEAD_CYC 3, so one carrier is 40 cycles. */
`default_nettype none
module tpw_top_tb
	import tpw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic oc_n = 1'b1;
	logic slow = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic [11:0] adc_data;
	wire logic adc_valid, adc_start, trig, irq;
	wire logic [1:0] adc_channel;
	wire logic [3:0] irq_level;
	wire logic [5:0] g;
	wire logic [8:0] obs = {|g, irq, trig, g};
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int c;
	logic [31:0] v;
	// high cycles per carrier: duty d exceeds the count 2d-1 times, less the dead window
	int hi[7] = '{16, 18, 6, 28, 26, 8, 1};
	always #12.5 mclk = ~mclk;
	tpw_top #(.PERIOD(12'h014), .DEAD_CYC(3)) uut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .overcurrent_stop_input_n(oc_n), .gate_up(g[0]), .gate_un(g[1]),
		.gate_vp(g[2]), .gate_vn(g[3]), .gate_wp(g[4]), .gate_wn(g[5]), .trough_conversion_trigger(trig),
		.adc_start, .adc_channel, .adc_data, .adc_valid, .irq, .irq_level);
	tpw_adc_model u_adc (.mclk, .rst_n, .slow, .adc_start, .adc_channel, .adc_data, .adc_valid);
	task automatic finish_test();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		ck(d, e);
	endtask
	// counts high cycles of one observed output
	task automatic cnt(input int i, input int n, output int k);
		k = 0;
		repeat (n)
		begin
			@(posedge mclk);
			#1;
			k += (obs[i] === 1'b0) ? 0 : 1; // an unknown counts as high, so a zero expectation catches it
		end
	endtask
	// waits for a trigger, then lets the converter sequence finish
	task automatic settle();
		int k = 0;
		while (obs[6] !== 1'b1 && k < 200)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		ck(32'(obs[6]), 32'h1);
		repeat (30) @(posedge mclk);
	endtask
	// hang guard: the run needs about 2000 cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			errors = errors + 1;
			finish_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		ck(32'(adc_channel), 32'(TPW_CH_VDC));
		rdc(TPW_ADDR_STATUS, 32'h0000_0000);
		rdc(TPW_ADDR_IRQ_MASK, 32'h0000_0000);
		rdc(8'h30, 32'h0000_0000);
		wr(TPW_ADDR_DUTY_U, 32'h0000_000a);
		wr(TPW_ADDR_DUTY_V, 32'h0000_0005);
		wr(TPW_ADDR_DUTY_W, 32'h0000_000f);
		rdc(TPW_ADDR_DUTY_V, 32'h0000_0005);
		wr(TPW_ADDR_IRQ_MASK, 32'h0000_0003);
		wr(TPW_ADDR_CMD, 32'h0000_0015);
		repeat (20) @(posedge mclk);
		#1;
		ck(32'(irq), 32'h1);
		ck(32'(irq_level), 32'(TPW_LVL_CONV));
		wr(TPW_ADDR_IRQ_STAT, 32'h0000_0001);
		rdc(TPW_ADDR_IRQ_STAT, 32'h0000_0000);
		rdc(TPW_ADDR_RES_VDC, 32'h0000_05a3);
		rdc(TPW_ADDR_RES_IU, 32'h0000_05a0);
		rdc(TPW_ADDR_RES_IW, 32'h0000_05a2);
		slow <= 1'b1;
		foreach (hi[i])
		begin
			cnt(i, 160, c);
			ck(32'(c), 32'(hi[i] * 4));
		end
		// duty 0 lands at count 7 going down, while the old duty 10 is still in the upper leg's dead window;
		// the leg turns on at count 4 and the old value must hold it on until the trough
		settle();
		wr(TPW_ADDR_DUTY_U, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		cnt(0, 4, c);
		ck(32'(c), 32'h4);
		repeat (40) @(posedge mclk);
		cnt(0, 40, c);
		ck(32'(c), 32'h0);
		settle();
		wr(TPW_ADDR_CMD, 32'h0000_0002);
		rd(TPW_ADDR_STATUS, v);
		ck(v & 32'h0000_0001, 32'h0);
		cnt(6, 100, c);
		ck(32'(c), 32'h0);
		wr(TPW_ADDR_CMD, 32'h0000_0001);
		cnt(6, 80, c);
		ck(32'(c), 32'h2);
		settle();
		wr(TPW_ADDR_CMD, 32'h0000_0020);
		cnt(6, 80, c);
		ck(32'(c), 32'h0);
		wr(TPW_ADDR_CMD, 32'h0000_0010);
		// a short low pulse must not trip the stop
		@(posedge mclk);
		oc_n <= 1'b0;
		repeat (10) @(posedge mclk);
		oc_n <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(TPW_ADDR_STATUS, v);
		ck(v & 32'h0000_000b, 32'h0000_0003);
		@(posedge mclk);
		oc_n <= 1'b0;
		repeat (30) @(posedge mclk);
		#1;
		ck(32'(irq_level), 32'(TPW_LVL_OFF));
		rd(TPW_ADDR_STATUS, v);
		ck(v & 32'h0000_000b, 32'h0000_0009);
		@(posedge mclk);
		oc_n <= 1'b1;
		cnt(8, 80, c);
		ck(32'(c), 32'h0);
		wr(TPW_ADDR_IRQ_STAT, 32'h0000_0003);
		wr(TPW_ADDR_CMD, 32'h0000_0044);
		cnt(8, 80, c);
		ck(32'(c > 0), 32'h1);
		finish_test();
	end
endmodule
`default_nettype wire
